// ==== rtl/hmap_fifo.sv ====
// write queue between host writes and the memory write port
`timescale 1ns/10ps
module hmap_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // queue ends
  hmap_fifo_if.fifo q
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          do_push, do_pop;

  // ---------------------------------------------------------------
  // pointer and count update
  // ---------------------------------------------------------------
  always_comb
  begin
    do_push = q.in_valid && (cnt_q != FULL_CNT);
    do_pop  = q.out_ready && (cnt_q != '0);
    wp_d    = do_push ? ((wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1) : wp_q;
    rp_d    = do_pop ? ((rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1) : rp_q;
    cnt_d   = cnt_q;
    if (do_push && !do_pop)
      cnt_d = cnt_q + 1'b1;
    else if (do_pop && !do_push)
      cnt_d = cnt_q - 1'b1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (do_push)
      mem_q[wp_q] <= q.in_data;
  end

  assign q.in_ready  = (cnt_q != FULL_CNT);
  assign q.out_valid = (cnt_q != '0);
  assign q.out_data  = mem_q[rp_q];
endmodule

// ==== rtl/hmap_fifo_if.sv ====
// valid/ready link between the port sequencer and its write queue
`timescale 1ns/10ps
interface hmap_fifo_if #(parameter int W = 8);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, input in_data, input out_ready,
                output in_ready, output out_valid, output out_data);
  modport user (output in_valid, output in_data, output out_ready,
                input in_ready, input out_valid, input out_data);
endinterface

// ==== rtl/hmap_pkg.sv ====
// constants shared by the host memory access port and its write queue
package hmap_pkg;
  // ---------------------------------------------------------------
  // widths and write queue depth
  // ---------------------------------------------------------------
  localparam int BUS_W     = 16;
  localparam int PMW_W     = 24;
  localparam int SYNC_W    = 20;
  localparam int CNT_W     = 4;
  localparam int WQ_W      = 1 + BUS_W + PMW_W;
  localparam int WQ_DEPTH  = 16;
  // ---------------------------------------------------------------
  // synchroniser bit positions
  // ---------------------------------------------------------------
  localparam int SY_SEL    = 19;
  localparam int SY_LAT    = 18;
  localparam int SY_WR     = 17;
  localparam int SY_RD     = 16;
  // ---------------------------------------------------------------
  // address field selecting program memory
  // ---------------------------------------------------------------
  localparam int PM_SEL_BIT = 14;
  // ---------------------------------------------------------------
  // timing: least busy time after write start, in half clock periods
  // ---------------------------------------------------------------
  localparam int ACK_MIN_HALF_CK = 3;
  localparam logic [CNT_W-1:0] ACK_MIN_CYC = CNT_W'((ACK_MIN_HALF_CK + 1) / 2);
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [SYNC_W-1:0] SYNC_RST = 20'hb_0000;
  localparam logic [BUS_W-1:0]  BUS_RST  = 16'h0000;
  localparam logic [PMW_W-1:0]  WORD_RST = 24'h00_0000;
  // ---------------------------------------------------------------
  // port sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b0_0001,
    ST_WR   = 5'b0_0010,
    ST_WEND = 5'b0_0100,
    ST_RD   = 5'b0_1000,
    ST_REND = 5'b1_0000
  } hmap_state_e;
endpackage

// ==== rtl/hmap_port.sv ====
// host memory access port: strobe sequencer, acknowledge and bus drive
`timescale 1ns/10ps
module hmap_port (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       nrst,
  // host pins
  input  wire logic                       port_select_n,
  input  wire logic                       addr_latch_strobe,
  input  wire logic                       host_write_n,
  input  wire logic                       host_read_n,
  input  wire logic [hmap_pkg::BUS_W-1:0] bus_in,
  output logic      [hmap_pkg::BUS_W-1:0] bus_out,
  output logic                            bus_oe,
  output logic                            port_ack_n,
  // memory read port
  output logic                            mem_rd_req,
  output logic                            mem_rd_pm,
  output logic      [hmap_pkg::BUS_W-1:0] mem_rd_addr,
  input  wire logic                       mem_rd_valid,
  input  wire logic [hmap_pkg::PMW_W-1:0] mem_rd_data,
  // memory write port
  output logic                            mem_wr_valid,
  output logic                            mem_wr_pm,
  output logic      [hmap_pkg::BUS_W-1:0] mem_wr_addr,
  output logic      [hmap_pkg::PMW_W-1:0] mem_wr_data,
  input  wire logic                       mem_wr_ready
);
  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  logic [hmap_pkg::SYNC_W-1:0] s1_q, s2_q;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q <= hmap_pkg::SYNC_RST;
      s2_q <= hmap_pkg::SYNC_RST;
    end
    else
    begin
      s1_q <= {port_select_n, addr_latch_strobe, host_write_n, host_read_n, bus_in};
      s2_q <= s1_q;
    end
  end

  logic [hmap_pkg::BUS_W-1:0] bus_s;
  logic lat_now, wr_now, rd_now;
  logic [2:0] ph_q;
  logic lat_end, wr_start, wr_end, rd_start, rd_end;
  assign bus_s    = s2_q[hmap_pkg::BUS_W-1:0];
  assign lat_now  = ~s2_q[hmap_pkg::SY_SEL] & s2_q[hmap_pkg::SY_LAT];
  assign wr_now   = ~s2_q[hmap_pkg::SY_SEL] & ~s2_q[hmap_pkg::SY_WR];
  assign rd_now   = ~s2_q[hmap_pkg::SY_SEL] & ~s2_q[hmap_pkg::SY_RD];
  assign lat_end  = ph_q[2] & ~lat_now;
  assign wr_start = wr_now & ~ph_q[1];
  assign wr_end   = ph_q[1] & ~wr_now;
  assign rd_start = rd_now & ~ph_q[0];
  assign rd_end   = ph_q[0] & ~rd_now;

  // ---------------------------------------------------------------
  // write queue
  // ---------------------------------------------------------------
  hmap_fifo_if #(.W(hmap_pkg::WQ_W)) wq ();
  hmap_fifo #(.W(hmap_pkg::WQ_W), .DEPTH(hmap_pkg::WQ_DEPTH)) u_wq (
    .clk  (clk),
    .nrst (nrst),
    .q    (wq.fifo)
  );

  // ---------------------------------------------------------------
  // port sequencer
  // ---------------------------------------------------------------
  hmap_pkg::hmap_state_e      st_q, st_d;
  logic                       ack_q, ack_d, oe_q, oe_d, half_q, half_d;
  logic                       wend_q, wend_d, fetch_q, fetch_d, rreq_q, rreq_d;
  logic [hmap_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [hmap_pkg::BUS_W-1:0] addr_q, addr_d, out_q, out_d, wdat_q, wdat_d;
  logic [hmap_pkg::BUS_W-1:0] pmhi_q, pmhi_d, wdata_c;
  logic [hmap_pkg::PMW_W-1:0] rdbuf_q, rdbuf_d;
  logic                       push_c, is_pm;
  logic [hmap_pkg::WQ_W-1:0]  push_data_c;
  logic                       mwv_q, mwv_d;
  logic [hmap_pkg::WQ_W-1:0]  mw_q, mw_d;

  function automatic logic [hmap_pkg::BUS_W-1:0] read_word(
    input logic [hmap_pkg::PMW_W-1:0] buf_w, input logic pm, input logic second);
    if (!pm)
      read_word = buf_w[15:0];
    else if (!second)
      read_word = buf_w[23:8];
    else
      read_word = {8'h00, buf_w[7:0]};
  endfunction

  assign is_pm = addr_q[hmap_pkg::PM_SEL_BIT];

  always_comb
  begin
    st_d = st_q;
    ack_d = ack_q;
    oe_d = oe_q;
    half_d = half_q;
    wend_d = wend_q;
    fetch_d = fetch_q;
    rreq_d = rreq_q;
    cnt_d = (cnt_q == '1) ? cnt_q : cnt_q + 1'b1;
    addr_d = addr_q;
    out_d = out_q;
    wdat_d = wdat_q;
    pmhi_d = pmhi_q;
    rdbuf_d = rdbuf_q;
    push_c = 1'b0;
    push_data_c = '0;
    wdata_c = wend_q ? wdat_q : bus_s;
    case (st_q)
      hmap_pkg::ST_IDLE:
      begin
        if (lat_end)
        begin
          addr_d = bus_s;
          half_d = 1'b0;
        end
        else if (wr_start)
        begin
          ack_d = 1'b1;
          cnt_d = '0;
          wend_d = 1'b0;
          st_d = hmap_pkg::ST_WR;
        end
        else if (rd_start)
        begin
          ack_d = 1'b1;
          oe_d = 1'b1;
          out_d = read_word(rdbuf_q, is_pm, half_q);
          fetch_d = ~(is_pm & half_q);
          cnt_d = '0;
          st_d = hmap_pkg::ST_RD;
        end
      end
      hmap_pkg::ST_WR:
      begin
        if (wr_end && !wend_q)
        begin
          wend_d = 1'b1;
          wdat_d = bus_s;
        end
        if (cnt_q >= hmap_pkg::ACK_MIN_CYC - 1'b1 && (wq.in_ready || (is_pm && !half_q)))
        begin
          ack_d = 1'b0;
          if (is_pm && !half_q)
          begin
            pmhi_d = wdata_c;
            half_d = 1'b1;
          end
          else
          begin
            push_c = 1'b1;
            half_d = 1'b0;
            push_data_c = is_pm ? {1'b1, addr_q, pmhi_q, wdata_c[7:0]}
                                : {1'b0, addr_q, 8'h00, wdata_c};
          end
          st_d = (wend_q || wr_end) ? hmap_pkg::ST_IDLE : hmap_pkg::ST_WEND;
        end
      end
      hmap_pkg::ST_WEND:
      begin
        if (!wr_now)
          st_d = hmap_pkg::ST_IDLE;
      end
      hmap_pkg::ST_RD:
      begin
        if (rd_end)
          oe_d = 1'b0;
        if (!fetch_q)
        begin
          if (cnt_q >= hmap_pkg::ACK_MIN_CYC - 1'b1)
          begin
            ack_d = 1'b0;
            half_d = 1'b0;
            st_d = hmap_pkg::ST_REND;
          end
        end
        else if (rreq_q && mem_rd_valid)
        begin
          rreq_d = 1'b0;
          rdbuf_d = mem_rd_data;
          ack_d = 1'b0;
          half_d = is_pm;
          st_d = hmap_pkg::ST_REND;
        end
        else if (!rreq_q && !wq.out_valid && !mwv_q)
          rreq_d = 1'b1;
      end
      hmap_pkg::ST_REND:
      begin
        if (!rd_now)
        begin
          oe_d = 1'b0;
          st_d = hmap_pkg::ST_IDLE;
        end
      end
      default:
      begin
        st_d = hmap_pkg::ST_IDLE;
        ack_d = 1'b0;
        oe_d = 1'b0;
        rreq_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= hmap_pkg::ST_IDLE;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
      half_q <= 1'b0;
      wend_q <= 1'b0;
      fetch_q <= 1'b0;
      rreq_q <= 1'b0;
      cnt_q <= '0;
      addr_q <= hmap_pkg::BUS_RST;
      out_q <= hmap_pkg::BUS_RST;
      wdat_q <= hmap_pkg::BUS_RST;
      pmhi_q <= hmap_pkg::BUS_RST;
      rdbuf_q <= hmap_pkg::WORD_RST;
      ph_q <= 3'h0;
    end
    else
    begin
      st_q <= st_d;
      ack_q <= ack_d;
      oe_q <= oe_d;
      half_q <= half_d;
      wend_q <= wend_d;
      fetch_q <= fetch_d;
      rreq_q <= rreq_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      out_q <= out_d;
      wdat_q <= wdat_d;
      pmhi_q <= pmhi_d;
      rdbuf_q <= rdbuf_d;
      ph_q <= {lat_now, wr_now, rd_now};
    end
  end

  // ---------------------------------------------------------------
  // memory write stage
  // ---------------------------------------------------------------
  assign wq.in_valid  = push_c;
  assign wq.in_data   = push_data_c;
  assign wq.out_ready = ~mwv_q | mem_wr_ready;

  always_comb
  begin
    mwv_d = mwv_q;
    mw_d = mw_q;
    if (wq.out_ready && wq.out_valid)
    begin
      mwv_d = 1'b1;
      mw_d = wq.out_data;
    end
    else if (mem_wr_ready)
      mwv_d = 1'b0;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mwv_q <= 1'b0;
      mw_q <= '0;
    end
    else
    begin
      mwv_q <= mwv_d;
      mw_q <= mw_d;
    end
  end

  assign port_ack_n   = ack_q;
  assign bus_oe       = oe_q;
  assign bus_out      = out_q;
  assign mem_rd_req   = rreq_q;
  assign mem_rd_pm    = addr_q[hmap_pkg::PM_SEL_BIT];
  assign mem_rd_addr  = addr_q;
  assign mem_wr_valid = mwv_q;
  assign mem_wr_pm    = mw_q[hmap_pkg::WQ_W-1];
  assign mem_wr_addr  = mw_q[hmap_pkg::WQ_W-2 -: hmap_pkg::BUS_W];
  assign mem_wr_data  = mw_q[hmap_pkg::PMW_W-1:0];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_sync_two_stage: assert property (##2 s2_q[hmap_pkg::SY_WR] == $past(host_write_n, 2))
    else $error("write strobe not delayed by two stages");
  chk_addr_capture: assert property (st_q == hmap_pkg::ST_IDLE && lat_end |=> addr_q == $past(bus_s))
    else $error("address not captured at latch end");
  chk_wr_busy_min: assert property (st_q == hmap_pkg::ST_IDLE && !lat_end && wr_start |=> ack_q [*2])
    else $error("acknowledge busy shorter than minimum after write");
  chk_short_wr_data: assert property (st_q == hmap_pkg::ST_WR && wr_end && !wend_q |=> wdat_q == $past(bus_s))
    else $error("short write data not taken at write end");
  chk_long_wr_data: assert property (push_c && !wend_q && !is_pm |-> push_data_c[15:0] == bus_s)
    else $error("long write data not taken at acknowledge fall");
  chk_rd_prev_word: assert property (st_q == hmap_pkg::ST_IDLE && !lat_end && !wr_start && rd_start && !is_pm
    |=> oe_q && out_q == $past(rdbuf_q[15:0]))
    else $error("read did not drive previously fetched word");
  chk_rd_fetch_ack: assert property (st_q == hmap_pkg::ST_RD && rreq_q && mem_rd_valid
    |=> !ack_q && rdbuf_q == $past(mem_rd_data))
    else $error("fetched word not stored with acknowledge low");
  chk_drive_till_end: assert property (st_q == hmap_pkg::ST_REND && rd_now |=> oe_q)
    else $error("bus released before read end");
  chk_release_bus: assert property (st_q == hmap_pkg::ST_REND && !rd_now |=> !oe_q ##1 !oe_q)
    else $error("bus not released after read");
  chk_pm_second_half: assert property (push_c && push_data_c[hmap_pkg::WQ_W-1] |-> half_q)
    else $error("program word pushed before second half");
  chk_pm2_no_fetch: assert property (st_q == hmap_pkg::ST_RD && !fetch_q |-> !rreq_q)
    else $error("second half read started a fetch");

  cov_short_write: cover property (st_q == hmap_pkg::ST_WR && wr_end ##[1:8] push_c);
  cov_long_write: cover property (push_c && !wend_q && !wr_end);
  cov_dm_read: cover property (st_q == hmap_pkg::ST_RD && rreq_q && mem_rd_valid && !is_pm);
  cov_pm_read2: cover property (st_q == hmap_pkg::ST_RD && !fetch_q ##[1:8] !ack_q);
endmodule

// ==== verification/hmap_mem_model.sv ====
// memory model answering the port's read and write requests
`timescale 1ns/10ps
module hmap_mem_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // read side
  input  wire logic        rd_req,
  input  wire logic        rd_pm,
  input  wire logic [15:0] rd_addr,
  output logic             rd_valid,
  output logic [23:0]      rd_data,
  // write side
  input  wire logic        wr_valid,
  input  wire logic        wr_pm,
  input  wire logic [15:0] wr_addr,
  input  wire logic [23:0] wr_data,
  output logic             wr_ready,
  // bench control
  input  wire logic        stall,
  output int               n_wr
);
  logic [23:0] mem [0:65535];
  int          wait_q;
  logic        done_q;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_valid <= 1'b0;
      rd_data  <= 24'h5a_5a5a;
      wr_ready <= 1'b0;
      wait_q   <= 0;
      done_q   <= 1'b0;
      n_wr     <= 0;
    end
    else
    begin
      rd_valid <= 1'b0;
      rd_data  <= 24'($urandom);
      wr_ready <= !stall && ($urandom % 4 != 0);
      if (!rd_req)
        done_q <= 1'b0;
      else if (!done_q && wait_q == 0)
        wait_q <= 1 + $urandom % 4;
      else if (!done_q && wait_q == 1)
      begin
        rd_valid <= 1'b1;
        // the kind flag, not the address bit, picks the memory
        rd_data  <= mem[{rd_addr[15], rd_pm, rd_addr[13:0]}];
        done_q   <= 1'b1;
        wait_q   <= 0;
      end
      else if (!done_q)
        wait_q <= wait_q - 1;
      if (wr_valid && wr_ready)
      begin
        mem[{wr_addr[15], wr_pm, wr_addr[13:0]}] <= wr_data;
        n_wr         <= n_wr + 1;
      end
    end
  end
endmodule

// ==== verification/host_memory_access_port_test.sv ====
// self-checking bench for the host memory access port
`timescale 1ns/10ps
module host_memory_access_port_test;
  logic        clk, nrst, stall, host_oe, last_pm;
  logic        port_select_n, addr_latch_strobe, host_write_n, host_read_n;
  logic        bus_oe, port_ack_n, mem_rd_req, mem_rd_pm, mem_rd_valid;
  logic        mem_wr_valid, mem_wr_pm, mem_wr_ready;
  logic [15:0] bus_in, bus_out, mem_rd_addr, mem_wr_addr, host_bus, idle_q;
  logic [23:0] mem_rd_data, mem_wr_data, last_w;
  logic [23:0] shadow [logic [15:0]];
  int          n_wr, err_count, n_checks, hold_n, max_n, exp_wr;
  // ---------------------------------------------------------------
  // design, memory model and shared bus
  // ---------------------------------------------------------------
  assign bus_in = bus_oe ? bus_out : host_oe ? host_bus : idle_q;
  always @(posedge clk) idle_q <= #1 (nrst ? ~idle_q : 16'h5a5a);
  hmap_port DUT (.clk(clk), .nrst(nrst), .port_select_n(port_select_n),
    .addr_latch_strobe(addr_latch_strobe), .host_write_n(host_write_n),
    .host_read_n(host_read_n), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
    .port_ack_n(port_ack_n), .mem_rd_req(mem_rd_req), .mem_rd_pm(mem_rd_pm),
    .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
    .mem_wr_valid(mem_wr_valid), .mem_wr_pm(mem_wr_pm), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready));
  hmap_mem_model mem_model (.clk(clk), .nrst(nrst), .rd_req(mem_rd_req),
    .rd_pm(mem_rd_pm), .wr_pm(mem_wr_pm),
    .rd_addr(mem_rd_addr), .rd_valid(mem_rd_valid), .rd_data(mem_rd_data),
    .wr_valid(mem_wr_valid), .wr_addr(mem_wr_addr), .wr_data(mem_wr_data),
    .wr_ready(mem_wr_ready), .stall(stall), .n_wr(n_wr));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [23:0] prev_word(input logic [23:0] w, input logic pm);
    prev_word = pm ? {8'h00, w[23:8]} : {8'h00, w[15:0]};
  endfunction
  function automatic logic [23:0] stored(input logic [15:0] a, input logic [23:0] w);
    stored = a[14] ? w : {8'h00, w[15:0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_ack(output int n);
    n = 0;
    while (port_ack_n !== 1'b0 && n < 400)
    begin
      tick(1);
      n++;
    end
    if (n >= 400)
    begin
      check(24'h1, 24'h0);
      summarize();
    end
  endtask
  task automatic latch(input logic [15:0] a);
    wait_ack(hold_n);
    host_bus          = a;
    host_oe           = 1'b1;
    port_select_n     = 1'b0;
    addr_latch_strobe = 1'b1;
    tick(3);
    if ($urandom % 2)
      port_select_n = 1'b1;
    else
      addr_latch_strobe = 1'b0;
    tick(3);
    port_select_n     = 1'b1;
    addr_latch_strobe = 1'b0;
    host_oe           = 1'b0;
    tick(2);
  endtask
  task automatic access(input logic wr, input logic [15:0] d, input logic lng,
                        output logic [15:0] got);
    wait_ack(hold_n);
    host_bus      = d;
    host_oe       = wr;
    port_select_n = 1'b0;
    host_write_n  = !wr;
    host_read_n   = wr;
    tick(1);
    if (wr && !lng)
      host_write_n = 1'b1;
    tick(1);
    check(24'(port_ack_n), 24'h0);
    tick(1);
    check(24'(port_ack_n), 24'h1);
    got = bus_out;
    check(24'(bus_oe), 24'(!wr));
    wait_ack(hold_n);
    if (wr)
      check(24'(hold_n >= 2), 24'h1);
    else
      check({bus_oe, 7'h0, bus_out}, {8'h80, got});
    max_n = (wr && hold_n > max_n) ? hold_n : max_n;
    tick(1);
    port_select_n = 1'b1;
    host_write_n  = 1'b1;
    host_read_n   = 1'b1;
    tick(3);
    check(24'(bus_oe), 24'h0);
    host_oe = 1'b0;
  endtask
  task automatic wr_word(input logic [15:0] a, input logic [23:0] w);
    logic [15:0] g;
    latch(a);
    exp_wr++;
    if (a[14])
    begin
      access(1'b1, w[23:8], 1'($urandom), g);
      access(1'b1, {8'($urandom), w[7:0]}, 1'($urandom), g);
      shadow[a] = stored(a, w);
    end
    else
    begin
      access(1'b1, w[15:0], 1'($urandom), g);
      shadow[a] = stored(a, w);
    end
  endtask
  task automatic rd_word(input logic [15:0] a);
    logic [15:0] g;
    latch(a);
    access(1'b0, 16'h0000, 1'b0, g);
    if (!a[14] && !last_pm)
      check(24'(g), prev_word(last_w, 1'b0));
    if (a[14] && last_pm)
      check(24'(g), prev_word(last_w, 1'b1));
    last_w  = shadow[a];
    last_pm = a[14];
    if (a[14])
    begin
      access(1'b0, 16'h0000, 1'b0, g);
      check(24'(g), {16'h0000, last_w[7:0]});
    end
  endtask
  // ---------------------------------------------------------------
  // clock and main sequence
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    int n;
    {port_select_n, host_write_n, host_read_n, addr_latch_strobe} = 4'b1110;
    {nrst, stall, host_oe, last_pm} = 4'b0000;
    host_bus = 16'h0000;
    last_w   = 24'h00_0000;
    void'($urandom(32'hbd29dc7b));
    tick(5);
    nrst = 1'b1;
    tick(1);
    for (int i = 0; i < 12; i++)
      wr_word(16'($urandom), 24'($urandom));
    $display("test random_writes done");
    stall = 1'b1;
    fork
      begin
        tick(500);
        stall = 1'b0;
      end
    join_none
    for (int i = 0; i < 24; i++)
      wr_word(16'h0100 + 16'(i), i == 0 ? 24'hff_ffff : 24'($urandom));
    check(24'(max_n > 20), 24'h1);
    n = 0;
    while (n_wr != exp_wr && n < 400)
    begin
      tick(1);
      n++;
    end
    check(24'(n_wr), 24'(exp_wr));
    if (n >= 400)
      summarize();
    $display("test queue_fill done");
    foreach (shadow[a])
      rd_word(a);
    foreach (shadow[a])
      check(mem_model.mem[a], shadow[a]);
    $display("test read_back done");
    summarize();
  end
endmodule
